// >>> hw/smah_set_max_address_handler.sv
// Overview of operation
// - command code F9h selects this command handler
// - F9h changes the limit only right after read native max address
// - otherwise feature 01h..04h selects password, lock, unlock, freeze
// - new limit clipped to native capacity; later accesses beyond it abort
// - identify words 61:60 report the new limit after success
// - second non-volatile change aborts until power-on or hardware reset
// - limit change aborts while locked or frozen
// - with 48-bit support words 103:100 hold the full limit; 61:60 cap it at 0FFFFFFFh
// - request of 268435455 on large drive gives native max in 103:100
// - abort if a protected area was set by the 48-bit command
// - sector count bit 0 selects non-volatile; invalid in offset mode
// - LBA in sector number, cylinders and head; CHS uses cylinders only
// - return limit in same registers; CHS returns sector 63, cyl, head
`timescale 1ns/1ps
`default_nettype none
module smah_set_max_address_handler
  import smah_pkg::*;
#(
  parameter logic [47:0] NATIVE_MAX = 48'h0000_1000_0000,
  parameter logic [15:0] CHS_MAX_CYL = 16'h3FFF,
  parameter logic [3:0] CHS_MAX_HEAD = 4'hF,
  parameter bit LBA48_SUPPORTED = 1'b1
) (
  // clock and resets
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_hw_rst,
  // taskfile written by the host
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd,
  input wire logic [7:0] i_feature,
  input wire logic [7:0] i_sec_count,
  input wire logic [7:0] i_sec_num,
  input wire logic [7:0] i_cyl_lo,
  input wire logic [7:0] i_cyl_hi,
  input wire logic [7:0] i_dev_head,
  // device state inputs
  input wire logic i_addr_offset_mode,
  input wire logic i_hpa_ext_set,
  // media access check
  input wire logic i_acc_valid,
  input wire logic [47:0] i_acc_lba,
  // answer registers
  output logic o_done,
  output logic [7:0] o_status,
  output logic [7:0] o_error,
  output logic [7:0] o_sec_num,
  output logic [7:0] o_cyl_lo,
  output logic [7:0] o_cyl_hi,
  output logic [3:0] o_head,
  output logic o_acc_abort,
  // identify capacity words and security state
  output logic [27:0] o_id_w61_60,
  output logic [47:0] o_id_w103_100,
  output logic o_nv_set_q,
  output logic [3:0] o_sec_state
);
  if (NATIVE_MAX == 48'h0) begin : g_bad_native
    $error("native capacity must be nonzero");
  end
  logic rnm_prev_q;
  logic nv_done_q;
  logic [47:0] max_q;
  smah_sec_e sec_q;
  logic is_f9;
  logic is_set;
  logic [47:0] req;
  logic [47:0] new_max;
  logic abort;
  logic big_28;
  logic [15:0] chs_cyl;
  logic [27:0] ret28;
  assign is_f9 = i_cmd_valid && (i_cmd == CMD_SET_MAX);
  assign is_set = is_f9 && rnm_prev_q;
  // a cylinder beyond the geometry is held to the last one
  assign chs_cyl = ({i_cyl_hi, i_cyl_lo} > CHS_MAX_CYL) ? CHS_MAX_CYL :
    {i_cyl_hi, i_cyl_lo};
  // LBA mode takes all four fields, CHS mode the cylinder only
  assign req = i_dev_head[DH_LBA_BIT] ?
    {20'h0, i_dev_head[3:0], i_cyl_hi, i_cyl_lo, i_sec_num} :
    {32'h0, chs_cyl};
  assign big_28 = (NATIVE_MAX > LBA28_LIMIT) &&
    (req == LBA28_LIMIT);
  assign new_max = big_28 ? NATIVE_MAX :
    ((req > NATIVE_MAX) ? NATIVE_MAX : req);
  // a limit past the 28-bit range reads back as the 28-bit maximum
  assign ret28 = (new_max > LBA28_LIMIT) ? LBA28_LIMIT[27:0] :
    new_max[27:0];
  assign abort = (sec_q == SMAH_LOCKED) || (sec_q == SMAH_FROZEN)
    || i_hpa_ext_set
    || (i_sec_count[SC_NV_BIT] && (nv_done_q
    || i_addr_offset_mode));
  // read native max flag
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_hw_rst) begin
      rnm_prev_q <= 1'b0;
    end else if (i_cmd_valid) begin
      rnm_prev_q <= (i_cmd == CMD_READ_NATIVE);
    end
  end
  // limit survives a hardware reset; only power-on reset reloads it
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      max_q <= NATIVE_MAX;
    end else if (is_set && !abort && !i_hw_rst) begin
      max_q <= new_max;
    end
  end
  // non-volatile lock-out
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_hw_rst) begin
      nv_done_q <= 1'b0;
    end else if (is_set && !abort && i_sec_count[SC_NV_BIT]) begin
      nv_done_q <= 1'b1;
    end
  end
  // security extension state
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_hw_rst) begin
      sec_q <= SMAH_UNLOCKED;
    end else if (is_f9 && !rnm_prev_q) begin
      unique case (i_feature)
        FEAT_LOCK: if (sec_q == SMAH_UNLOCKED) sec_q <= SMAH_LOCKED;
        FEAT_UNLOCK: if (sec_q == SMAH_LOCKED) sec_q <= SMAH_UNLOCKED;
        FEAT_FREEZE: if (sec_q == SMAH_UNLOCKED) sec_q <= SMAH_FROZEN;
        default: sec_q <= sec_q;
      endcase
    end
  end
  // command answer
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_hw_rst) begin
      o_done <= 1'b0;
      o_status <= STATUS_RESET;
      o_error <= ERROR_RESET;
      o_sec_num <= 8'h00;
      o_cyl_lo <= 8'h00;
      o_cyl_hi <= 8'h00;
      o_head <= 4'h0;
    end else begin
      o_done <= is_f9;
      if (is_f9) begin
        o_status <= STATUS_RESET;
        o_error <= ERROR_RESET;
        if ((is_set && abort) || (!is_set &&
            (i_feature < FEAT_SET_PW || i_feature > FEAT_FREEZE ||
            sec_q == SMAH_FROZEN))) begin
          o_status[ST_ERR_BIT] <= 1'b1;
          o_error[ERR_ABT_BIT] <= 1'b1;
        end else if (is_set) begin
          if (i_dev_head[DH_LBA_BIT]) begin
            o_sec_num <= ret28[7:0];
            o_cyl_lo <= ret28[15:8];
            o_cyl_hi <= ret28[23:16];
            o_head <= ret28[27:24];
          end else begin
            // limit is the cylinder; sector and head report the geometry
            o_sec_num <= CHS_MAX_SECTOR;
            o_cyl_lo <= new_max[7:0];
            o_cyl_hi <= new_max[15:8];
            o_head <= CHS_MAX_HEAD;
          end
        end
      end
    end
  end
  // identify words and access check
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_hw_rst) begin
      o_id_w61_60 <= 28'h0;
      o_id_w103_100 <= 48'h0;
      o_acc_abort <= 1'b0;
    end else begin
      o_id_w61_60 <= (max_q > LBA28_LIMIT) ? LBA28_LIMIT[27:0] :
        max_q[27:0];
      o_id_w103_100 <= LBA48_SUPPORTED ? max_q : 48'h0;
      o_acc_abort <= i_acc_valid && (i_acc_lba > max_q);
    end
  end
  assign o_nv_set_q = nv_done_q;
  assign o_sec_state = sec_q;
  chk_lock_abort: assert property (
    @(posedge i_clk_sys) disable iff (i_rst || i_hw_rst)
    is_set && sec_q == SMAH_LOCKED |=> o_error[ERR_ABT_BIT])
    else $error("set in locked state not aborted");
  chk_abort_keep: assert property (
    @(posedge i_clk_sys) disable iff (i_rst || i_hw_rst)
    is_set && abort |=> $stable(max_q))
    else $error("abort changed limit");
  chk_no_rnm: assert property (
    @(posedge i_clk_sys) disable iff (i_rst || i_hw_rst)
    is_f9 && !rnm_prev_q |=> $stable(max_q))
    else $error("limit changed without read native max");
  chk_flag_clear: assert property (
    @(posedge i_clk_sys) disable iff (i_rst || i_hw_rst)
    i_cmd_valid && i_cmd != CMD_READ_NATIVE |=> !rnm_prev_q)
    else $error("preceding flag not cleared");
  chk_flag_set: assert property (
    @(posedge i_clk_sys) disable iff (i_rst || i_hw_rst)
    i_cmd_valid && i_cmd == CMD_READ_NATIVE |=> rnm_prev_q)
    else $error("preceding flag not set");
  chk_nv_second: assert property (
    @(posedge i_clk_sys) disable iff (i_rst || i_hw_rst)
    is_set && nv_done_q && i_sec_count[SC_NV_BIT] |=> o_status[ST_ERR_BIT])
    else $error("second nonvolatile set not aborted");
  chk_hpa_abort: assert property (
    @(posedge i_clk_sys) disable iff (i_rst || i_hw_rst)
    is_set && i_hpa_ext_set |=> o_error[ERR_ABT_BIT])
    else $error("set after 48-bit area not aborted");
  chk_limit_cap: assert property (
    @(posedge i_clk_sys) disable iff (i_rst || i_hw_rst)
    max_q <= NATIVE_MAX)
    else $error("limit above native capacity");
  chk_acc_abort: assert property (
    @(posedge i_clk_sys) disable iff (i_rst || i_hw_rst)
    i_acc_valid && i_acc_lba > max_q |=> o_acc_abort)
    else $error("access beyond limit not aborted");
  chk_id_match: assert property (
    @(posedge i_clk_sys) disable iff (i_rst || i_hw_rst)
    is_set && !abort && !big_28 |=> ##1
      ({20'h0, o_id_w61_60} == $past(new_max, 2) || max_q > LBA28_LIMIT))
    else $error("identify words not updated");
  chk_id_wide: assert property (
    @(posedge i_clk_sys) disable iff (i_rst || i_hw_rst)
    1'b1 |=> !LBA48_SUPPORTED || o_id_w103_100 == $past(max_q))
    else $error("wide identify words differ from limit");
  chk_big_native: assert property (
    @(posedge i_clk_sys) disable iff (i_rst || i_hw_rst)
    is_set && !abort && big_28 |=> max_q == NATIVE_MAX)
    else $error("full 28-bit request did not give native limit");
  chk_abort_code: assert property (
    @(posedge i_clk_sys) disable iff (i_rst || i_hw_rst)
    o_done && o_status[ST_ERR_BIT] |-> o_error[ERR_ABT_BIT]
      && o_status[ST_RDY_BIT] && !o_status[ST_COR_BIT])
    else $error("abort answer bits wrong");
  chk_answer_ok: assert property (
    @(posedge i_clk_sys) disable iff (i_rst || i_hw_rst)
    is_f9 |=> o_done && !o_status[ST_BSY_BIT] && !o_status[ST_DF_BIT])
    else $error("answer status bits wrong");
endmodule
`default_nettype wire

// >>> hw/smah_pkg.sv
package smah_pkg;
  // command codes
  localparam logic [7:0] CMD_SET_MAX = 8'hF9;
  localparam logic [7:0] CMD_READ_NATIVE = 8'hF8;
  localparam logic [7:0] CMD_SET_MAX_EXT = 8'h37;
  // feature values of the security extensions
  localparam logic [7:0] FEAT_SET_PW = 8'h01;
  localparam logic [7:0] FEAT_LOCK = 8'h02;
  localparam logic [7:0] FEAT_UNLOCK = 8'h03;
  localparam logic [7:0] FEAT_FREEZE = 8'h04;
  // field positions
  localparam int SC_NV_BIT = 0;
  localparam int DH_LBA_BIT = 6;
  localparam int ERR_ABT_BIT = 2;
  localparam int ST_BSY_BIT = 7;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_DF_BIT = 5;
  localparam int ST_COR_BIT = 2;
  localparam int ST_ERR_BIT = 0;
  // limits and CHS geometry
  localparam logic [47:0] LBA28_LIMIT = 48'h0000_0FFF_FFFF;
  localparam logic [7:0] CHS_MAX_SECTOR = 8'h3F;
  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h40;
  localparam logic [7:0] ERROR_RESET = 8'h00;
  typedef enum logic [3:0] {
    SMAH_UNLOCKED = 4'b0001,
    SMAH_LOCKED = 4'b0010,
    SMAH_FROZEN = 4'b0100,
    SMAH_UNUSED = 4'b1000
  } smah_sec_e;
endpackage

// >>> verif/smah_host.sv
`timescale 1ns/1ps
`default_nettype none
module smah_host
  import smah_pkg::*;
(
  // clock and answer
  input wire logic i_clk_sys,
  input wire logic i_done,
  // taskfile
  output logic o_cmd_valid,
  output logic [7:0] o_cmd,
  output logic [7:0] o_feature,
  output logic [7:0] o_sec_count,
  output logic [7:0] o_sec_num,
  output logic [7:0] o_cyl_lo,
  output logic [7:0] o_cyl_hi,
  output logic [7:0] o_dev_head
);
  initial begin
    {o_cmd_valid, o_cmd, o_feature, o_sec_count} = '0;
    {o_sec_num, o_cyl_lo, o_cyl_hi, o_dev_head} = '0;
  end
  task automatic issue(input logic [7:0] c, f, sc, input logic l,
                       input logic [27:0] a, output logic ok);
    int n;
    @(negedge i_clk_sys);
    o_cmd_valid = 1'b1;
    o_cmd = c;
    o_feature = f;
    o_sec_count = sc;
    {o_dev_head[3:0], o_cyl_hi, o_cyl_lo, o_sec_num} = a;
    o_dev_head[7:4] = {1'b1, l, 2'b10};
    @(negedge i_clk_sys);
    o_cmd_valid = 1'b0;
    o_cmd = ~c;
    ok = (c != CMD_SET_MAX);
    for (n = 0; n < 4 && !ok; n++) begin
      if (i_done === 1'b1) ok = 1'b1;
      else @(negedge i_clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// >>> verif/set_max_address_handler_tb.sv
`timescale 1ns/1ps
`default_nettype none
module set_max_address_handler_tb;
  import smah_pkg::*;
  localparam logic [47:0] NMAX = 48'h0000_1000_0000;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_hw_rst = 1'b0;
  logic om = 1'b0, hpa = 1'b0, av = 1'b0, ok;
  logic [47:0] al = '0;
  logic v, done, ab, nv;
  logic [7:0] c, f, sc, sn, cl, ch, dh, st, er, osn, ocl, och;
  logic [3:0] hd, ss;
  logic [27:0] w61;
  logic [47:0] w103;
  int miscompares = 0;
  int samples_checked = 0;
  always #4 i_clk_sys = ~i_clk_sys;
  smah_host i_host (.i_clk_sys, .i_done(done), .o_cmd_valid(v), .o_cmd(c),
    .o_feature(f), .o_sec_count(sc), .o_sec_num(sn), .o_cyl_lo(cl),
    .o_cyl_hi(ch), .o_dev_head(dh));
  smah_set_max_address_handler #(.NATIVE_MAX(NMAX)) i_dut (.i_clk_sys,
    .i_rst, .i_hw_rst, .i_cmd_valid(v), .i_cmd(c), .i_feature(f),
    .i_sec_count(sc), .i_sec_num(sn), .i_cyl_lo(cl), .i_cyl_hi(ch),
    .i_dev_head(dh), .i_addr_offset_mode(om), .i_hpa_ext_set(hpa),
    .i_acc_valid(av), .i_acc_lba(al), .o_done(done), .o_status(st),
    .o_error(er), .o_sec_num(osn), .o_cyl_lo(ocl), .o_cyl_hi(och),
    .o_head(hd), .o_acc_abort(ab), .o_id_w61_60(w61),
    .o_id_w103_100(w103), .o_nv_set_q(nv), .o_sec_state(ss));
  task automatic end_sim();
    if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic cmd(input logic [7:0] k, fe, s, input logic [27:0] a);
    i_host.issue(k, fe, s, 1'b1, a, ok);
  endtask
  // read native max directly followed by the limit change
  task automatic set(input logic [7:0] s, input logic l, input logic [27:0] a);
    i_host.issue(CMD_READ_NATIVE, 8'h00, 8'h00, 1'b1, 28'h0, ok);
    i_host.issue(CMD_SET_MAX, 8'h00, s, l, a, ok);
  endtask
  task automatic ans(input logic [7:0] s, e);
    chk(ok, 1'b1, "no done");
    chk(st, s, "status");
    chk(er, e, "error");
  endtask
  task automatic acc(input logic [47:0] a, input logic exp);
    @(negedge i_clk_sys);
    av = 1'b1;
    al = a;
    @(negedge i_clk_sys);
    av = 1'b0;
    chk(ab, exp, "access");
  endtask
  task automatic t_lba();
    set(8'h00, 1'b1, 28'h0123456);
    ans(8'h40, 8'h00);
    chk({hd, och, ocl, osn}, 28'h0123456, "returned");
    repeat (2) @(negedge i_clk_sys);
    chk(w61, 28'h0123456, "w61");
    chk(w103, 48'h0123456, "w103");
    acc(48'h0123456, 1'b0);
    acc(48'h0123457, 1'b1);
  endtask
  task automatic t_big();
    set(8'h00, 1'b1, 28'hFFFFFFF);
    ans(8'h40, 8'h00);
    chk({hd, och, ocl, osn}, 28'hFFFFFFF, "returned big");
    repeat (2) @(negedge i_clk_sys);
    chk(w61, 28'hFFFFFFF, "w61 big");
    chk(w103, NMAX, "w103 big");
    acc(NMAX, 1'b0);
  endtask
  task automatic t_order();
    cmd(CMD_READ_NATIVE, 8'h00, 8'h00, 28'h0);
    cmd(8'hEC, 8'h00, 8'h00, 28'h0);
    cmd(CMD_SET_MAX, 8'h00, 8'h00, 28'h0000100);
    ans(8'h41, 8'h04);
    repeat (2) @(negedge i_clk_sys);
    chk(w103, NMAX, "limit kept");
  endtask
  task automatic t_nv();
    set(8'h01, 1'b1, 28'h0200000);
    ans(8'h40, 8'h00);
    chk(nv, 1'b1, "nv set");
    set(8'h01, 1'b1, 28'h0100000);
    ans(8'h41, 8'h04);
    repeat (2) @(negedge i_clk_sys);
    chk(w103, 48'h0200000, "nv kept");
    i_hw_rst = 1'b1;
    @(negedge i_clk_sys);
    i_hw_rst = 1'b0;
    chk(nv, 1'b0, "hw reset");
    repeat (2) @(negedge i_clk_sys);
    chk(w103, 48'h0200000, "limit over hw reset");
    om = 1'b1;
    set(8'h01, 1'b1, 28'h0100000);
    ans(8'h41, 8'h04);
    om = 1'b0;
    hpa = 1'b1;
    set(8'h00, 1'b1, 28'h0100000);
    ans(8'h41, 8'h04);
    hpa = 1'b0;
  endtask
  task automatic t_chs();
    set(8'h00, 1'b0, 28'h0010000);
    ans(8'h40, 8'h00);
    chk({hd, och, ocl, osn}, 28'hF01003F, "chs");
  endtask
  task automatic t_sec();
    cmd(CMD_SET_MAX, FEAT_SET_PW, 8'h00, 28'h0);
    ans(8'h40, 8'h00);
    cmd(CMD_SET_MAX, FEAT_LOCK, 8'h00, 28'h0);
    chk(ss, 4'h2, "locked");
    set(8'h00, 1'b1, 28'h0000400);
    ans(8'h41, 8'h04);
    cmd(CMD_SET_MAX, FEAT_UNLOCK, 8'h00, 28'h0);
    chk(ss, 4'h1, "unlocked");
    cmd(CMD_SET_MAX, FEAT_FREEZE, 8'h00, 28'h0);
    chk(ss, 4'h4, "frozen");
    set(8'h00, 1'b1, 28'h0000400);
    ans(8'h41, 8'h04);
    cmd(CMD_SET_MAX, FEAT_SET_PW, 8'h00, 28'h0);
    ans(8'h41, 8'h04);
    chk(ss, 4'h4, "still frozen");
  endtask
  initial begin
    repeat (12) @(negedge i_clk_sys);
    i_rst = 1'b0;
    chk({st, er}, 16'h4000, "reset");
    t_lba();
    t_big();
    t_order();
    t_nv();
    t_chs();
    t_sec();
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge i_clk_sys);
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
